// [design/cbsr_pkg.sv]
// Constants shared by the cell balance status and readback block.
// Assumes a 125 MHz system clock and a 32-bit classic Wishbone slave port.
package cbsr_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ = 125_000_000;
    localparam int unsigned TIMER_TICK_S = 1;
    localparam int unsigned TICK_CYCLES = CLK_FREQ_HZ * TIMER_TICK_S;
    localparam logic [11:0] SECS_PER_SEC = 12'h001;
    localparam logic [11:0] SECS_PER_MIN = 12'h03c;
    localparam logic [11:0] SECS_PER_HOUR = 12'he10;

    // ------------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_CONTROL = 8'h80;
    localparam logic [7:0] IDX_STATUS = 8'h81;
    localparam logic [7:0] IDX_UV_EXIT = 8'h82;
    localparam logic [7:0] IDX_XFER = 8'h83;
    localparam logic [7:0] IDX_EXPIRY = 8'h84;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h85;
    localparam logic [7:0] IDX_IRQ_CLR = 8'h86;
    localparam logic [7:0] IDX_IRQ_EN = 8'h87;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned MODE_HI = 13;
    localparam int unsigned MODE_LO = 11;
    localparam int unsigned HOLD_HI = 9;
    localparam int unsigned HOLD_LO = 8;
    localparam int unsigned MEAS_HI = 1;
    localparam int unsigned MEAS_LO = 0;
    localparam int unsigned ACT_HI = 15;
    localparam int unsigned ACT_LO = 14;
    localparam int unsigned UNIT_HI = 13;
    localparam int unsigned UNIT_LO = 12;
    localparam int unsigned RDY_BIT = 13;
    localparam int unsigned SCAN_BIT = 0;
    localparam int unsigned NUM_CELLS = 14;
    localparam int unsigned NUM_EVENTS = 4;

    // ------------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_EMERG = 3'h1;
    localparam logic [2:0] MODE_MAN_SEC = 3'h2;
    localparam logic [2:0] MODE_MAN_MIN = 3'h3;
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_RUN = 2'h1;
    localparam logic [1:0] ACT_DONE = 2'h2;
    localparam logic [1:0] ACT_HALT = 2'h3;
    localparam logic [1:0] UNIT_NONE = 2'h0;
    localparam logic [1:0] UNIT_SEC = 2'h1;
    localparam logic [1:0] UNIT_MIN = 2'h2;
    localparam logic [1:0] UNIT_HOUR = 2'h3;
    localparam logic [9:0] EXPIRY_INFINITE = 10'h3ff;
    localparam logic [9:0] EXPIRY_RESET = 10'h000;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;

    // Activity states, one-hot.
    typedef enum logic [3:0] {
        CBSR_ST_OFF = 4'h1,
        CBSR_ST_RUN = 4'h2,
        CBSR_ST_DONE = 4'h4,
        CBSR_ST_HALT = 4'h8
    } cbsr_state_t;

endpackage : cbsr_pkg

// [design/cbsr_top.sv]
// Cell balance status and readback register bank with timer and flags.
// Assumes a Wishbone classic master, and measurement, alert and cell
// configuration inputs from logic on the same clock.
`timescale 1ns/1ps

module cbsr_top
    import cbsr_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [13:0] cell_below_uv_i,
    input wire logic [13:0] cell_switch_allow_i,
    input wire logic [13:0] cell_measure_enable_i,
    input wire logic [13:0] cell_polarity_select_i,
    input wire logic balance_thermal_exit_alert_i,
    input wire logic balance_timeout_alert_i,
    input wire logic balance_cal_fault_alert_i,
    input wire logic results_moved_i,
    output logic iir_to_result_strobe_o,
    output logic result_ready_flag_o,
    output logic [13:0] cell_balance_on_o,
    output logic [1:0] activity_o,
    output logic irq_o
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic ack_q;
    logic [31:0] rdata_q;
    wire req = wb_cyc_i & wb_stb_i;
    wire fire = req & ack_q;
    wire wr = fire & wb_we_i;
    wire [7:0] idx = wb_adr_i[9:2];
    wire lo_en = wb_sel_i[0];
    wire hi_en = wb_sel_i[1];
    wire wr_ctrl = wr & (idx == IDX_CONTROL);
    wire wr_xfer = wr & (idx == IDX_XFER);
    wire wr_exp = wr & (idx == IDX_EXPIRY);
    wire wr_iclr = wr & (idx == IDX_IRQ_CLR) & lo_en;
    wire wr_ien = wr & (idx == IDX_IRQ_EN) & lo_en;

    // ------------------------------------------------------------------
    // Control and expiry storage
    // ------------------------------------------------------------------
    logic [15:0] ctrl_q;
    logic [9:0] expiry_q;
    wire [15:0] ctrl_wdata = {hi_en ? wb_dat_i[15:8] : ctrl_q[15:8],
                              lo_en ? wb_dat_i[7:0] : ctrl_q[7:0]};
    // Only mode, hold select and measurement enable are stored.
    wire [15:0] ctrl_mask = 16'h3b03;
    wire [2:0] mode = ctrl_q[MODE_HI:MODE_LO];
    wire [1:0] hold_sel = ctrl_q[HOLD_HI:HOLD_LO];
    wire [1:0] meas_en = ctrl_q[MEAS_HI:MEAS_LO];
    wire [2:0] new_mode = ctrl_wdata[MODE_HI:MODE_LO];
    wire [9:0] exp_wdata = {hi_en ? wb_dat_i[9:8] : expiry_q[9:8],
                            lo_en ? wb_dat_i[7:0] : expiry_q[7:0]};

    // Software writes the configuration; a control write itself restarts work.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_q <= CONTROL_RESET;
            expiry_q <= EXPIRY_RESET;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= ctrl_wdata & ctrl_mask;
            if (wr_exp)
                expiry_q <= exp_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Timer unit and prescalers
    // ------------------------------------------------------------------
    wire manual = (mode == MODE_MAN_SEC) | (mode == MODE_MAN_MIN);
    wire auto_mode = mode[2];
    // Off has no unit, emergency counts hours, other odd codes minutes, even codes seconds.
    wire [1:0] unit = (mode == MODE_OFF) ? UNIT_NONE :
                      (mode == MODE_EMERG) ? UNIT_HOUR :
                      mode[0] ? UNIT_MIN : UNIT_SEC;
    wire [11:0] unit_secs = (unit == UNIT_HOUR) ? SECS_PER_HOUR :
                            (unit == UNIT_MIN) ? SECS_PER_MIN :
                            SECS_PER_SEC;

    cbsr_state_t state_q;
    cbsr_state_t state_d;
    logic [26:0] cyc_cnt_q;
    logic [11:0] sec_cnt_q;
    logic [9:0] timer_q;
    wire restart = wr_ctrl;
    wire running = (state_q == CBSR_ST_RUN);
    wire sec_tick = (cyc_cnt_q == 27'(TICK_CYCLES_P - 1));
    wire unit_tick = sec_tick & (sec_cnt_q == unit_secs - 12'h001);
    wire infinite = (expiry_q == EXPIRY_INFINITE);
    wire expired = running & ~infinite & (timer_q == expiry_q);

    // Seconds prescaler and elapsed counter; 10-bit wrap is deliberate.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || restart || !running)
        begin
            cyc_cnt_q <= 27'h0000000;
            sec_cnt_q <= 12'h000;
        end
        else
        begin
            cyc_cnt_q <= sec_tick ? 27'h0000000 : cyc_cnt_q + 27'h0000001;
            if (sec_tick)
                sec_cnt_q <= unit_tick ? 12'h000 : sec_cnt_q + 12'h001;
        end
    end

    // The elapsed count advances one unit per unit tick while running.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || restart)
            timer_q <= 10'h000;
        else if (running && unit_tick && !expired)
            timer_q <= timer_q + 10'h001;
    end

    // ------------------------------------------------------------------
    // Undervoltage exit flags
    // ------------------------------------------------------------------
    logic [13:0] uv_flag_q;
    logic [13:0] uv_set;
    wire uv_check = running & auto_mode & (meas_en == 2'h3);
    genvar g;
    generate
        for (g = 0; g < NUM_CELLS; g = g + 1)
        begin : g_cell
            // A cell without a usable unipolar measurement cannot be
            // checked, so it is ended with its flag raised.
            wire unsupported = ~cell_measure_enable_i[g] |
                               cell_polarity_select_i[g];
            assign uv_set[g] = uv_check & cell_switch_allow_i[g] &
                               (cell_below_uv_i[g] | unsupported);
        end
    endgenerate
    wire all_exit = uv_check & ((uv_flag_q | ~cell_switch_allow_i) ==
                                14'h3fff) & (cell_switch_allow_i != 14'h0);

    // Flags persist until disable or a new start via the control write.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || restart)
            uv_flag_q <= 14'h0000;
        else
            uv_flag_q <= uv_flag_q | uv_set;
    end

    // ------------------------------------------------------------------
    // Activity state machine
    // ------------------------------------------------------------------
    wire halt_evt = balance_thermal_exit_alert_i | balance_timeout_alert_i |
                    balance_cal_fault_alert_i;

    // Disable wins, a control write starts anew, then halts, then ends.
    always_comb
    begin
        state_d = state_q;
        if (restart)
            state_d = (new_mode == MODE_OFF) ? CBSR_ST_OFF : CBSR_ST_RUN;
        else
            unique case (state_q)
                CBSR_ST_OFF: state_d = CBSR_ST_OFF;
                CBSR_ST_RUN:
                begin
                    if (halt_evt)
                        state_d = CBSR_ST_HALT;
                    else if (expired || all_exit)
                        state_d = CBSR_ST_DONE;
                end
                CBSR_ST_DONE: state_d = CBSR_ST_DONE;
                CBSR_ST_HALT: state_d = CBSR_ST_HALT;
                default: state_d = CBSR_ST_OFF;
            endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            state_q <= CBSR_ST_OFF;
        else
            state_q <= state_d;
    end

    wire [1:0] act_code = (state_q == CBSR_ST_RUN) ? ACT_RUN :
                          (state_q == CBSR_ST_DONE) ? ACT_DONE :
                          (state_q == CBSR_ST_HALT) ? ACT_HALT :
                          ACT_OFF;
    // Hold extension after a completed run shows the governing expiry.
    wire [9:0] timer_view = ((state_q == CBSR_ST_DONE) && hold_sel[1]) ?
                            expiry_q : timer_q;

    // ------------------------------------------------------------------
    // Transfer strobe and result-ready flag
    // ------------------------------------------------------------------
    logic ready_q;
    logic strobe_q;
    logic xfer_pend_q;
    wire scan_allowed = (mode != MODE_OFF) & ~manual &
                        meas_en[1];
    wire scan_req = wr_xfer & lo_en & wb_dat_i[SCAN_BIT] & scan_allowed;
    wire ready_clr = wr_xfer & hi_en & ~wb_dat_i[RDY_BIT];
    wire ready_set = results_moved_i;

    // The strobe is a one-cycle pulse; the ready flag's set beats clear.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            strobe_q <= 1'b0;
            xfer_pend_q <= 1'b0;
            ready_q <= 1'b0;
        end
        else
        begin
            strobe_q <= scan_req;
            xfer_pend_q <= scan_req | (xfer_pend_q & ~results_moved_i);
            if (ready_set)
                ready_q <= 1'b1;
            else if (ready_clr)
                ready_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status, clear and enable
    // ------------------------------------------------------------------
    logic [3:0] irq_stat_q;
    logic [3:0] irq_en_q;
    wire entering_done = running & (state_d == CBSR_ST_DONE);
    wire entering_halt = running & (state_d == CBSR_ST_HALT);
    wire [3:0] evt = {ready_set & ~ready_q, entering_halt, entering_done,
                      |(uv_set & ~uv_flag_q)};
    wire [3:0] clr_bits = wr_iclr ? wb_dat_i[NUM_EVENTS-1:0] : 4'h0;

    // Events set sticky bits; a set in the clear cycle is kept.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            irq_stat_q <= 4'h0;
            irq_en_q <= 4'h0;
            irq_o <= 1'b0;
        end
        else
        begin
            irq_stat_q <= (irq_stat_q & ~clr_bits) | evt;
            if (wr_ien)
                irq_en_q <= wb_dat_i[NUM_EVENTS-1:0];
            irq_o <= |(((irq_stat_q & ~clr_bits) | evt) & irq_en_q);
        end
    end

    // ------------------------------------------------------------------
    // Read mux and acknowledge
    // ------------------------------------------------------------------
    wire [15:0] rd_status = {act_code, unit, 2'h0, timer_view};
    wire [15:0] rd_uv = {act_code, uv_flag_q};
    wire [15:0] rd_xfer = {act_code, ready_q, 13'h0000};
    wire [15:0] rd_sel = (idx == IDX_CONTROL) ? ctrl_q :
                         (idx == IDX_STATUS) ? rd_status :
                         (idx == IDX_UV_EXIT) ? rd_uv :
                         (idx == IDX_XFER) ? rd_xfer :
                         (idx == IDX_EXPIRY) ? {6'h00, expiry_q} :
                         (idx == IDX_IRQ_STAT) ? {12'h000, irq_stat_q} :
                         (idx == IDX_IRQ_EN) ? {12'h000, irq_en_q} :
                         16'h0000;

    // Ack follows one cycle after the request and drops the next cycle.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= req & ~ack_q;
            if (req && !ack_q)
                rdata_q <= {16'h0000, rd_sel};
        end
    end

    // Registered copies of the balance switch enables and the activity code.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            cell_balance_on_o <= 14'h0000;
            activity_o <= ACT_OFF;
        end
        else
        begin
            cell_balance_on_o <= running ? (cell_switch_allow_i &
                                 ~uv_flag_q & ~uv_set) : 14'h0000;
            activity_o <= act_code;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign iir_to_result_strobe_o = strobe_q;
    assign result_ready_flag_o = ready_q;

endmodule : cbsr_top

// [test/cbsr_top_assertions.sv]
// Port-level checker for the cell balance status and readback block.
// Assumes it is bound to cbsr_top and clocked by its system clock.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Checker
// ------------------------------------------------------------------
module cbsr_top_assertions
    import cbsr_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic balance_thermal_exit_alert_i,
    input wire logic results_moved_i,
    input wire logic iir_to_result_strobe_o,
    input wire logic result_ready_flag_o,
    input wire logic [1:0] activity_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // Committed writes to the transfer register, decoded by lane.
    wire xfer_wr = wb_ack_o && wb_we_i && wb_adr_i[9:2] == IDX_XFER;
    wire strobe_wr = xfer_wr && wb_sel_i[0] && wb_dat_i[0];
    wire clear_wr = xfer_wr && wb_sel_i[1] && !wb_dat_i[13];

    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack stayed high");
    a_ack_after_req: assert property
        ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not acknowledged");
    a_no_idle_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_upper_half_zero: assert property
        (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_strobe_one_pulse: assert property
        (iir_to_result_strobe_o |=> !iir_to_result_strobe_o)
        else $error("transfer strobe held");
    a_strobe_has_cause: assert property
        (iir_to_result_strobe_o |-> $past(strobe_wr) || $past(strobe_wr, 2))
        else $error("transfer strobe without write");
    a_ready_on_move: assert property
        (results_moved_i |=> result_ready_flag_o)
        else $error("ready not set after results moved");
    a_ready_clear_cause: assert property
        ($fell(result_ready_flag_o) |-> $past(clear_wr))
        else $error("ready cleared without zero write");
    a_alert_halts_run: assert property
        ((activity_o == ACT_RUN && balance_thermal_exit_alert_i && !wb_ack_o)
        |-> ##[1:2] activity_o == ACT_HALT)
        else $error("alert did not halt balancing");

    c_strobe: cover property (iir_to_result_strobe_o);
    c_ready: cover property ($rose(result_ready_flag_o));
    c_halt: cover property (activity_o == ACT_HALT);
endmodule : cbsr_top_assertions

bind cbsr_top cbsr_top_assertions cbsr_top_assertions_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .results_moved_i(results_moved_i),
    .balance_thermal_exit_alert_i(balance_thermal_exit_alert_i),
    .iir_to_result_strobe_o(iir_to_result_strobe_o),
    .result_ready_flag_o(result_ready_flag_o), .activity_o(activity_o)
);

// [test/test_cbsr_top.sv]
// Self-checking bench for the cell balance status and readback block.
// Assumes the checker is bound in; the tick is shortened to 4 cycles.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin \
miscompares++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end

// ------------------------------------------------------------------
// Bench
// ------------------------------------------------------------------
module test_cbsr_top;
    import cbsr_pkg::*;
    logic clock_i = 0, rst_n_i = 0, cyc = 0, stb = 0, we = 0;
    logic thermal = 0, moved = 0;
    logic [9:0] adr = '0;
    logic [3:0] sel = '0;
    logic [31:0] dat = '0;
    logic [13:0] below = '0, allow = '0, meas = '0, pol = '0;
    wire [31:0] rdat;
    wire [13:0] bal_on;
    wire [1:0] act;
    wire ack, strobe, ready, irq;
    logic [15:0] q;
    int miscompares = 0, checked = 0, strobes = 0;
    logic [1:0] units [8] = '{UNIT_NONE, UNIT_HOUR, UNIT_SEC, UNIT_MIN,
        UNIT_SEC, UNIT_MIN, UNIT_SEC, UNIT_MIN};
    logic [15:0] refused [4] = '{16'h1002, 16'h1802, 16'h0002, 16'h2001};

    cbsr_top #(.TICK_CYCLES_P(4)) cbsr_top_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .cell_below_uv_i(below), .cell_switch_allow_i(allow),
        .cell_measure_enable_i(meas), .cell_polarity_select_i(pol),
        .balance_thermal_exit_alert_i(thermal),
        .balance_timeout_alert_i(1'b0), .balance_cal_fault_alert_i(1'b0),
        .results_moved_i(moved), .iir_to_result_strobe_o(strobe),
        .result_ready_flag_o(ready), .cell_balance_on_o(bal_on),
        .activity_o(act), .irq_o(irq)
    );

    // Clock and a counter of transfer strobe pulses.
    always #4 clock_i = ~clock_i;
    always @(posedge clock_i)
        if (strobe === 1'b1) strobes <= strobes + 1;

    task automatic ticks(input int n);
        repeat (n) @(posedge clock_i);
    endtask : ticks

    // One classic cycle; ack and read data are taken at the rising edge.
    // Only the watchdog ends a wait for an answer that never comes.
    task automatic xfer(input logic w, input logic [7:0] i,
        input logic [15:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        sel <= 4'h3;
        dat <= {16'h0000, d};
        do
            @(posedge clock_i);
        while (ack !== 1'b1);
        q = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clock_i);
    endtask : xfer

    task automatic rdc(input string nm, input logic [7:0] i,
        input logic [15:0] ex);
        xfer(1'b0, i, 16'h0000);
        `CHK(nm, ex, q)
    endtask : rdc

    task automatic complete_run;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    // Watchdog against a hung handshake.
    initial
    begin
        ticks(12000);
        miscompares++;
        complete_run();
    end

    // Main sequence of register accesses.
    initial
    begin
        ticks(4);
        rst_n_i <= 1'b1;
        ticks(1);
        rdc("status", IDX_STATUS, 16'h0000);
        rdc("uv", IDX_UV_EXIT, 16'h0000);
        rdc("xfer", IDX_XFER, 16'h0000);
        xfer(1'b1, 8'h9c, 16'hffff);
        rdc("unmapped", 8'h9c, 16'h0000);
        xfer(1'b1, IDX_STATUS, 16'hffff);
        rdc("ro", IDX_STATUS, 16'h0000);
        for (int m = 0; m < 8; m++)
        begin
            xfer(1'b1, IDX_CONTROL, {2'b00, 3'(m), 11'h000});
            xfer(1'b0, IDX_STATUS, 16'h0000);
            `CHK("unit", units[m], q[13:12])
        end
        xfer(1'b1, IDX_EXPIRY, 16'h0003);
        xfer(1'b1, IDX_CONTROL, 16'h2202);
        ticks(40);
        rdc("done", IDX_STATUS, 16'h9003);
        rdc("irqst", IDX_IRQ_STAT, 16'h0002);
        `CHK("irq_mask", 1'b0, irq)
        xfer(1'b1, IDX_IRQ_EN, 16'h0002);
        @(negedge clock_i);
        `CHK("irq_on", 1'b1, irq)
        @(posedge clock_i);
        xfer(1'b1, IDX_IRQ_CLR, 16'h0002);
        rdc("irqclr", IDX_IRQ_STAT, 16'h0000);
        `CHK("irq_off", 1'b0, irq)
        xfer(1'b1, IDX_XFER, 16'h0001);
        ticks(3);
        `CHK("strobe", 1, strobes)
        rdc("strobe_rd", IDX_XFER, 16'h8000);
        moved <= 1'b1;
        ticks(1);
        moved <= 1'b0;
        ticks(2);
        rdc("ready", IDX_XFER, 16'ha000);
        `CHK("ready_pin", 1'b1, ready)
        xfer(1'b1, IDX_XFER, 16'h2000);
        rdc("ready_w1", IDX_XFER, 16'ha000);
        xfer(1'b1, IDX_XFER, 16'h0000);
        rdc("ready_w0", IDX_XFER, 16'h8000);
        `CHK("ready_pin_clr", 1'b0, ready)
        for (int k = 0; k < 4; k++)
        begin
            xfer(1'b1, IDX_CONTROL, refused[k]);
            xfer(1'b1, IDX_XFER, 16'h0001);
            ticks(3);
            `CHK("refused", 1, strobes)
        end
        xfer(1'b1, IDX_EXPIRY, 16'h03ff);
        allow <= 14'h0003;
        below <= 14'h0001;
        pol <= 14'h0002;
        meas <= 14'h3fff;
        xfer(1'b1, IDX_CONTROL, 16'h2203);
        ticks(10);
        rdc("uv_set", IDX_UV_EXIT, 16'h8003);
        `CHK("cells_off", 14'h0000, bal_on)
        // An early exit under hold shows the expiry, not the elapsed count.
        rdc("hold_view", IDX_STATUS, 16'h93ff);
        below <= 14'h0000;
        pol <= 14'h0000;
        xfer(1'b1, IDX_CONTROL, 16'h2003);
        rdc("uv_clr", IDX_UV_EXIT, 16'h4000);
        `CHK("cells_on", 14'h0003, bal_on)
        ticks(4400);
        xfer(1'b0, IDX_STATUS, 16'h0000);
        `CHK("wrap_act", 4'h5, q[15:12])
        `CHK("wrap_timer", 1'b1, q[9:0] < 10'd100)
        thermal <= 1'b1;
        ticks(1);
        thermal <= 1'b0;
        ticks(3);
        rdc("halt", IDX_UV_EXIT, 16'hc000);
        // A second reset after the halt returns the block to idle.
        rst_n_i <= 1'b0;
        ticks(4);
        rst_n_i <= 1'b1;
        ticks(1);
        rdc("reset_uv", IDX_UV_EXIT, 16'h0000);
        `CHK("reset_irq", 1'b0, irq)
        complete_run();
    end
endmodule : test_cbsr_top
